// ==== tmsr_smbus_regs.sv ====
// Bus slave, register file, limit checks and single-shot trigger
`timescale 1ns/1ps
`include "tmsr_regs.svh"
module tmsr_smbus_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Address straps, two bits each: 0 low, 1 open, 2 high
  input wire logic [1:0] addr_strap_a,
  input wire logic [1:0] addr_strap_b,
  // Serial link, clock and data sampled synchronously
  input wire logic serial_clock_line,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // Standby pin, active low
  input wire logic standby_pin_n,
  // Converter side
  input wire logic conv_done,
  input wire logic [7:0] raw_local_temp,
  input wire logic [7:0] raw_remote_temp,
  output logic conv_start,
  output logic conv_busy,
  // Status visibility
  output logic [7:0] status_flags,
  output logic [6:0] slave_address
);
  tmsr_pkg::tmsr_state_type state;
  logic [7:0] register_pointer;
  logic [7:0] local_high_limit;
  logic [7:0] local_low_limit;
  logic [7:0] remote_high_limit;
  logic [7:0] remote_low_limit;
  logic [7:0] remote_temp_correction;
  logic [7:0] config_reg;
  logic [7:0] rate_reg;
  logic [7:0] local_temp;
  logic [7:0] remote_temp;
  logic [3:0] sticky;
  logic [7:0] shift;
  logic [3:0] bit_count;
  logic byte_index;
  logic strap_taken;
  logic scl_prev;
  logic sda_prev;
  logic read_dir;
  logic [7:0] read_byte;
  logic lh_above;
  logic lh_below;
  logic rm_above;
  logic rm_below;
  logic [7:0] next_remote;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic status_read;
  logic wr_strobe;
  logic run_mode;
  logic shot_request;
  logic conv_request;
  logic [3:0] live_flags;
  logic addr_match;

  assign scl_rise = serial_clock_line & ~scl_prev;
  assign scl_fall = ~serial_clock_line & scl_prev;
  assign start_cond = serial_clock_line & scl_prev & sda_prev & ~serial_data_in;
  assign stop_cond = serial_clock_line & scl_prev & ~sda_prev & serial_data_in;
  assign addr_match = shift[7:1] == slave_address;

  function automatic logic [2:0] strap_code(input logic [1:0] s);
    case (s)
      2'h0: strap_code = 3'h0;
      2'h1: strap_code = 3'h1;
      default: strap_code = 3'h2;
    endcase
  endfunction : strap_code

  // Straps caught once after reset release, not under the async reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strap_taken <= 1'b0;
      slave_address <= 7'h00;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      case (strap_code(addr_strap_a))
        3'h0: slave_address <= 7'(`TMSR_ADDR_BASE_LOW + strap_code(addr_strap_b));
        3'h1: slave_address <= 7'(`TMSR_ADDR_BASE_OPEN + strap_code(addr_strap_b));
        default: slave_address <= 7'(`TMSR_ADDR_BASE_HIGH + strap_code(addr_strap_b));
      endcase
    end
  end

  // Idle-high reset values keep a false edge away after reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= serial_clock_line;
      sda_prev <= serial_data_in;
    end
  end

  // Write codes and unmapped codes return filler
  always_comb begin
    case (register_pointer)
      `TMSR_RD_LOCAL_TEMP: read_byte = local_temp;
      `TMSR_RD_REMOTE_TEMP: read_byte = remote_temp;
      `TMSR_RD_STATUS: read_byte = status_flags;
      `TMSR_RD_CONFIG: read_byte = config_reg;
      `TMSR_RD_RATE: read_byte = rate_reg;
      `TMSR_RD_LOCAL_HIGH: read_byte = local_high_limit;
      `TMSR_RD_LOCAL_LOW: read_byte = local_low_limit;
      `TMSR_RD_REMOTE_HIGH: read_byte = remote_high_limit;
      `TMSR_RD_REMOTE_LOW: read_byte = remote_low_limit;
      `TMSR_RW_CORRECTION: read_byte = remote_temp_correction;
      default: read_byte = `TMSR_FILLER;
    endcase
  end

  // Bus state machine; steps on falling clock, samples on rising clock
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= tmsr_pkg::tmsr_idle;
      shift <= 8'h00;
      bit_count <= 4'h0;
      byte_index <= 1'b0;
      read_dir <= 1'b0;
    end else if (start_cond) begin
      state <= tmsr_pkg::tmsr_addr;
      bit_count <= 4'h0;
      byte_index <= 1'b0;
    end else if (stop_cond) begin
      state <= tmsr_pkg::tmsr_idle;
    end else begin
      case (state)
        tmsr_pkg::tmsr_addr, tmsr_pkg::tmsr_wr_byte: begin
          if (scl_rise) begin
            shift <= {shift[6:0], serial_data_in};
            bit_count <= bit_count + 4'h1;
          end else if (scl_fall && bit_count == 4'h8) begin
            bit_count <= 4'h0;
            if (state == tmsr_pkg::tmsr_wr_byte) begin
              state <= tmsr_pkg::tmsr_wr_ack;
            end else if (addr_match) begin
              read_dir <= shift[0];
              state <= tmsr_pkg::tmsr_addr_ack;
            end else begin
              state <= tmsr_pkg::tmsr_idle;
            end
          end
        end
        tmsr_pkg::tmsr_addr_ack: begin
          if (scl_fall) begin
            state <= read_dir ? tmsr_pkg::tmsr_rd_byte : tmsr_pkg::tmsr_wr_byte;
            shift <= read_byte;
          end
        end
        tmsr_pkg::tmsr_wr_ack: begin
          if (scl_fall) begin
            byte_index <= 1'b1;
            // A third byte is not acknowledged
            state <= byte_index ? tmsr_pkg::tmsr_idle : tmsr_pkg::tmsr_wr_byte;
          end
        end
        tmsr_pkg::tmsr_rd_byte: begin
          if (scl_fall) begin
            shift <= {shift[6:0], 1'b1};
            bit_count <= bit_count + 4'h1;
            if (bit_count == 4'h7) begin
              state <= tmsr_pkg::tmsr_rd_ack;
              bit_count <= 4'h0;
            end
          end
        end
        tmsr_pkg::tmsr_rd_ack: begin
          // One byte per read, whatever the master answers
          if (scl_fall) begin
            state <= tmsr_pkg::tmsr_idle;
          end
        end
        default: state <= tmsr_pkg::tmsr_idle;
      endcase
    end
  end

  // Drive low for acknowledge and zero data bits; release otherwise
  always_comb begin
    case (state)
      tmsr_pkg::tmsr_addr_ack, tmsr_pkg::tmsr_wr_ack: serial_data_oe = 1'b1;
      tmsr_pkg::tmsr_rd_byte: serial_data_oe = ~shift[7];
      default: serial_data_oe = 1'b0;
    endcase
  end
  assign serial_data_out = 1'b0;

  // Byte completes at the ninth falling edge of a write
  assign wr_strobe = state == tmsr_pkg::tmsr_wr_ack && scl_fall;

  // Pointer takes the first byte of every write
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      register_pointer <= 8'h00;
    end else if (wr_strobe && !byte_index) begin
      register_pointer <= shift;
    end
  end

  // Read-only and unmapped codes fall to the default and change nothing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      local_high_limit <= `TMSR_RST_HIGH;
      local_low_limit <= `TMSR_RST_LOW;
      remote_high_limit <= `TMSR_RST_HIGH;
      remote_low_limit <= `TMSR_RST_LOW;
      remote_temp_correction <= `TMSR_RST_CORRECTION;
      config_reg <= `TMSR_RST_CONFIG;
      rate_reg <= `TMSR_RST_RATE;
    end else if (wr_strobe && byte_index) begin
      case (register_pointer)
        `TMSR_WR_CONFIG: config_reg <= shift;
        `TMSR_WR_RATE: rate_reg <= shift;
        `TMSR_WR_LOCAL_HIGH: local_high_limit <= shift;
        `TMSR_WR_LOCAL_LOW: local_low_limit <= shift;
        `TMSR_WR_REMOTE_HIGH: remote_high_limit <= shift;
        `TMSR_WR_REMOTE_LOW: remote_low_limit <= shift;
        `TMSR_RW_CORRECTION: remote_temp_correction <= shift;
        default: ;
      endcase
    end
  end

  // Conversion control; standby by config bit or low pin
  assign run_mode = ~config_reg[`TMSR_CFG_STANDBY_BIT] & standby_pin_n;
  // Write event fires the shot only with the config standby bit set; its data byte goes nowhere
  assign shot_request = wr_strobe && byte_index && register_pointer == `TMSR_WR_SINGLE_SHOT
    && config_reg[`TMSR_CFG_STANDBY_BIT];
  assign conv_request = standby_pin_n && !conv_busy && !conv_done
    && (run_mode || shot_request);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= conv_request;
    end
  end

  // Pin low or a finished conversion drops busy
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      conv_busy <= 1'b0;
    end else if (!standby_pin_n || conv_done) begin
      conv_busy <= 1'b0;
    end else if (conv_request) begin
      conv_busy <= 1'b1;
    end
  end

  // Signed add wraps at 8 bits, as the stored reading does
  assign next_remote = 8'(raw_remote_temp + remote_temp_correction);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      local_temp <= `TMSR_RST_TEMP;
      remote_temp <= `TMSR_RST_TEMP;
    end else if (conv_done && conv_busy && standby_pin_n) begin
      local_temp <= raw_local_temp;
      remote_temp <= next_remote;
    end
  end

  tmsr_limit_cmp u_local_cmp (
    .value(local_temp),
    .high_limit(local_high_limit),
    .low_limit(local_low_limit),
    .above(lh_above),
    .below(lh_below)
  );
  tmsr_limit_cmp u_remote_cmp (
    .value(remote_temp),
    .high_limit(remote_high_limit),
    .low_limit(remote_low_limit),
    .above(rm_above),
    .below(rm_below)
  );

  assign live_flags = {lh_above, lh_below, rm_above, rm_below};
  // Status read ends at the read acknowledge; set wins over clear
  assign status_read = state == tmsr_pkg::tmsr_rd_ack && scl_fall
    && register_pointer == `TMSR_RD_STATUS;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sticky <= 4'h0;
    end else if (status_read) begin
      sticky <= live_flags;
    end else begin
      sticky <= sticky | live_flags;
    end
  end

  // Low three bits read as zero; sensor fault is not modelled
  assign status_flags = {conv_busy, sticky, 3'h0};
endmodule : tmsr_smbus_regs

// ==== tmsr_regs.svh ====
// Register map, strap address bases and reset values of the temperature monitor bus front end
`ifndef TMSR_REGS_SVH
`define TMSR_REGS_SVH
`define TMSR_RD_LOCAL_TEMP 8'h00
`define TMSR_RD_REMOTE_TEMP 8'h01
`define TMSR_RD_STATUS 8'h02
`define TMSR_RD_CONFIG 8'h03
`define TMSR_RD_RATE 8'h04
`define TMSR_RD_LOCAL_HIGH 8'h05
`define TMSR_RD_LOCAL_LOW 8'h06
`define TMSR_RD_REMOTE_HIGH 8'h07
`define TMSR_RD_REMOTE_LOW 8'h08
`define TMSR_WR_CONFIG 8'h09
`define TMSR_WR_RATE 8'h0A
`define TMSR_WR_LOCAL_HIGH 8'h0B
`define TMSR_WR_LOCAL_LOW 8'h0C
`define TMSR_WR_REMOTE_HIGH 8'h0D
`define TMSR_WR_REMOTE_LOW 8'h0E
`define TMSR_WR_SINGLE_SHOT 8'h0F
`define TMSR_RW_CORRECTION 8'h11
`define TMSR_RST_TEMP 8'h80
`define TMSR_RST_HIGH 8'h7F
`define TMSR_RST_LOW 8'hC9
`define TMSR_RST_CONFIG 8'h00
`define TMSR_RST_RATE 8'h02
`define TMSR_RST_CORRECTION 8'h00
`define TMSR_FILLER 8'hFF
`define TMSR_CFG_STANDBY_BIT 6
`define TMSR_ST_BUSY_BIT 7
`define TMSR_ST_LHIGH_BIT 6
`define TMSR_ST_LLOW_BIT 5
`define TMSR_ST_RHIGH_BIT 4
`define TMSR_ST_RLOW_BIT 3
`define TMSR_ADDR_BASE_LOW 7'h18
`define TMSR_ADDR_BASE_OPEN 7'h29
`define TMSR_ADDR_BASE_HIGH 7'h4C
`endif

// ==== tmsr_pkg.sv ====
// Types shared by the temperature monitor bus front end
package tmsr_pkg;
  typedef enum logic [1:0] {tmsr_strap_low, tmsr_strap_open, tmsr_strap_high} tmsr_strap_type;
  typedef enum logic [2:0] {
    tmsr_idle, tmsr_addr, tmsr_addr_ack, tmsr_wr_byte, tmsr_wr_ack, tmsr_rd_byte, tmsr_rd_ack
  } tmsr_state_type;
endpackage : tmsr_pkg

// ==== tmsr_limit_cmp.sv ====
// Signed high and low limit comparator for one channel
`timescale 1ns/1ps
module tmsr_limit_cmp (
  // Measurement and limits
  input wire logic [7:0] value,
  input wire logic [7:0] high_limit,
  input wire logic [7:0] low_limit,
  // Alarms
  output logic above,
  output logic below
);
  // Equality is not an alarm
  assign above = $signed(value) > $signed(high_limit);
  assign below = $signed(value) < $signed(low_limit);
endmodule : tmsr_limit_cmp

// ==== tmsr_smbus_regs_monitor.sv ====
// Port checker for the bus front end
`timescale 1ns/1ps
module tmsr_smbus_regs_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Link
  input wire logic serial_clock_line,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  // Converter side
  input wire logic standby_pin_n,
  input wire logic conv_start,
  input wire logic conv_busy,
  // Status
  input wire logic [7:0] status_flags,
  input wire logic [6:0] slave_address
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_drive_low_only: assert property (serial_data_oe |-> !serial_data_out)
    else $error("data line driven high");
  a_oe_rise_low: assert property ($rose(serial_data_oe) |-> !serial_clock_line)
    else $error("pull-down began with clock high");
  a_oe_fall_low: assert property ($fell(serial_data_oe) |-> !serial_clock_line)
    else $error("pull-down ended with clock high");
  a_oe_stands: assert property ($rose(serial_data_oe) |=> serial_data_oe [*8])
    else $error("pull-down too short");
  a_addr_latched: assert property (
    !$past(reset) && !$past(reset, 2) |-> $stable(slave_address))
    else $error("slave address moved");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_pin_inhibit: assert property (!standby_pin_n && !$past(standby_pin_n)
    && !$past(standby_pin_n, 2) |-> !conv_start)
    else $error("start with standby pin low");
  a_busy_follows: assert property (conv_start |-> ##[0:1] conv_busy)
    else $error("busy missing after start");
  a_flag_spare: assert property (status_flags[2:0] == 3'h0)
    else $error("spare status bits set");
  c_start: cover property (conv_start);
  c_ack: cover property ($rose(serial_data_oe));
  c_rhigh: cover property (status_flags[4]);
endmodule : tmsr_smbus_regs_monitor

bind tmsr_smbus_regs tmsr_smbus_regs_monitor u_tmsr_smbus_regs_monitor (
  .ref_clk(ref_clk), .reset(reset), .serial_clock_line(serial_clock_line),
  .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
  .standby_pin_n(standby_pin_n), .conv_start(conv_start), .conv_busy(conv_busy),
  .status_flags(status_flags), .slave_address(slave_address));

// ==== tmsr_host_model.sv ====
// Bus master model on a pulled-up data line
`timescale 1ns/1ps
module tmsr_host_model (
  // Clock
  input wire logic ref_clk,
  // Link
  input wire logic serial_data_oe,
  output logic serial_clock_line,
  output logic serial_data_in
);
  logic sda_drive = 1'b1;
  logic scl_drive = 1'b1;
  assign serial_clock_line = scl_drive;
  // Pull-up wins unless someone pulls low
  assign serial_data_in = sda_drive & ~serial_data_oe;
  task automatic hp;
    repeat (8) @(posedge ref_clk);
  endtask : hp
  task automatic start;
    sda_drive <= 1'b1;
    scl_drive <= 1'b1;
    hp();
    sda_drive <= 1'b0;
    hp();
    scl_drive <= 1'b0;
    hp();
  endtask : start
  task automatic stop;
    sda_drive <= 1'b0;
    hp();
    scl_drive <= 1'b1;
    hp();
    sda_drive <= 1'b1;
    hp();
  endtask : stop
  task automatic bitx(input logic b, output logic r);
    sda_drive <= b;
    hp();
    scl_drive <= 1'b1;
    hp();
    hp();
    r = serial_data_in;
    scl_drive <= 1'b0;
    hp();
  endtask : bitx
  // Ones release the line; last high means not-acknowledge
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(last, ack);
  endtask : xfer
endmodule : tmsr_host_model

// ==== tmsr_smbus_regs_tb.sv ====
// Self-checking bench for the bus front end
`timescale 1ns/1ps
module tmsr_smbus_regs_tb;
  localparam logic [6:0] DEV = 7'h18;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] addr_strap_a = 2'h0;
  logic [1:0] addr_strap_b = 2'h0;
  logic standby_pin_n = 1'b0;
  logic conv_done = 1'b0;
  logic [7:0] raw_local_temp = 8'h1E;
  logic [7:0] raw_remote_temp = 8'h12;
  logic scl, sda, sda_out, sda_oe, conv_start, conv_busy;
  logic [7:0] status_flags, q;
  logic [6:0] slave_address;
  logic [6:0] bases [3] = '{7'h18, 7'h29, 7'h4C};
  int bad_count = 0;
  int cmp_count = 0;
  int starts = 0;
  tmsr_smbus_regs u_tmsr_smbus_regs (.ref_clk(ref_clk), .reset(reset),
    .addr_strap_a(addr_strap_a), .addr_strap_b(addr_strap_b), .serial_clock_line(scl),
    .serial_data_in(sda), .serial_data_out(sda_out), .serial_data_oe(sda_oe),
    .standby_pin_n(standby_pin_n), .conv_done(conv_done), .raw_local_temp(raw_local_temp),
    .raw_remote_temp(raw_remote_temp), .conv_start(conv_start), .conv_busy(conv_busy),
    .status_flags(status_flags), .slave_address(slave_address));
  tmsr_host_model u_tmsr_host_model (.ref_clk(ref_clk), .serial_data_oe(sda_oe),
    .serial_clock_line(scl), .serial_data_in(sda));
  initial forever #5 ref_clk = ~ref_clk;
  // Converter answers on the cycle after each start
  always @(posedge ref_clk) begin
    conv_done <= conv_start;
    if (conv_start) starts <= starts + 1;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic rst(input int n);
    reset <= 1'b1;
    repeat (n) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : rst
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, input int n);
    logic a;
    u_tmsr_host_model.start();
    u_tmsr_host_model.xfer({DEV, 1'b0}, 1'b1, q, a);
    check(a, 8'h00);
    u_tmsr_host_model.xfer(ptr, 1'b1, q, a);
    check(a, 8'h00);
    for (int i = 1; i < n; i++) begin
      u_tmsr_host_model.xfer(d, 1'b1, q, a);
      check(a, 8'(i > 1));
    end
    u_tmsr_host_model.stop();
  endtask : wr
  // New start for the read, direction cannot flip mid-transfer
  task automatic rd(output logic [7:0] v);
    logic a;
    u_tmsr_host_model.start();
    u_tmsr_host_model.xfer({DEV, 1'b1}, 1'b1, q, a);
    check(a, 8'h00);
    u_tmsr_host_model.xfer(8'hFF, 1'b1, v, a);
    u_tmsr_host_model.stop();
  endtask : rd
  task automatic rdp(input logic [7:0] ptr, input logic [7:0] want);
    wr(ptr, 8'h00, 1);
    rd(q);
    check(q, want);
  endtask : rdp
  task automatic t_straps;
    for (int i = 0; i < 9; i++) begin
      addr_strap_a <= 2'(i / 3);
      addr_strap_b <= 2'(i % 3);
      rst(2);
      addr_strap_a <= 2'h0;
      addr_strap_b <= 2'h0;
      repeat (3) @(posedge ref_clk);
      check(8'(slave_address), 8'(bases[i / 3] + 7'(i % 3)));
    end
  endtask : t_straps
  task automatic t_reset_vals;
    logic [7:0] want [5] = '{8'h7F, 8'hC9, 8'h7F, 8'hC9, 8'h00};
    for (int i = 0; i < 5; i++) rdp(i < 4 ? 8'(5 + i) : 8'h11, want[i]);
  endtask : t_reset_vals
  task automatic t_limits;
    wr(8'h0B, 8'h1E, 2);
    wr(8'h0C, 8'h1E, 2);
    wr(8'h0D, 8'h0D, 2);
    wr(8'h0E, 8'hF0, 3);
    wr(8'h11, 8'hFC, 2);
    wr(8'h0A, 8'h05, 2);
    rdp(8'h08, 8'hF0);
    rdp(8'h04, 8'h05);
    rdp(8'h11, 8'hFC);
    rdp(8'h0B, 8'hFF);
    rd(q);
    check(q, 8'hFF);
    rdp(8'h05, 8'h1E);
  endtask : t_limits
  task automatic t_single_shot;
    int s0;
    wr(8'h09, 8'h40, 2);
    rdp(8'h03, 8'h40);
    standby_pin_n <= 1'b1;
    repeat (20) @(posedge ref_clk);
    s0 = starts;
    wr(8'h0F, 8'h55, 2);
    repeat (20) @(posedge ref_clk);
    check(8'(starts - s0), 8'h01);
    // Low-limit flags from the reset readings stay until the status read
    check(status_flags, 8'h38);
    rdp(8'h01, 8'h0E);
    rdp(8'h0F, 8'hFF);
    rdp(8'h02, 8'h38);
    rdp(8'h02, 8'h10);
    standby_pin_n <= 1'b0;
    s0 = starts;
    wr(8'h0F, 8'h00, 2);
    repeat (20) @(posedge ref_clk);
    check(8'(starts - s0), 8'h00);
    wr(8'h09, 8'h00, 2);
    standby_pin_n <= 1'b1;
    s0 = starts;
    repeat (20) @(posedge ref_clk);
    check(8'(starts - s0 > 2), 8'h01);
  endtask : t_single_shot
  task automatic summarize;
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    #600_000;
    bad_count++;
    summarize();
  end
  initial begin
    rst(16);
    t_straps();
    rst(16);
    t_reset_vals();
    t_limits();
    t_single_shot();
    summarize();
  end
endmodule : tmsr_smbus_regs_tb
